// *** hw/sdtc_core.sv ***
// Purpose: Synchronous-rectifier dead-time compensator with Wishbone registers.
// Assumes: Two rectifiers, rect0 in the first half period, rect1 in the second.
// Notes:   Measurement of one cycle steers the turn-off edge of the next one.
// Operation
// [R1] Detection window opens after blanking following each gate falling edge.
// [R2] Manual mode applies the written offset; counts are still captured.
// [R3] Accumulated adjustment is clamped between programmable minimum and maximum.
// [R4] Falling edge always stays within 50% of the period.
// [R5] Automatic mode regulates conduction time toward a programmable target.
// [R6] Within the hysteresis band around the target the edge is not moved.
// [R7] Conduction below the fault threshold flags a negative-current fault.
// [R8] A fault step cuts next-cycle on-time by the programmed step size.
// [R9] Fault step only after the programmed number of consecutive faults.
// [R10] One enable bit switches the whole compensation on or off.
// [R11] Sense-low time counted only while the window is open.
// [R12] Separate conduction count per rectifier, 0 to 127.
// [R13] Measure in this cycle, apply the adjustment in the next cycle.
// [R14] Outside the band, move adjustment one step per cycle toward target.
// [R15] Fault step wins over the target step; result is still clamped.
`timescale 1ns/10ps
module sdtc_core (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [sdtc_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       conduction_sense0_n_i,
   input  wire logic                       conduction_sense1_n_i,
   output logic                            pulse_generator_output0_o,
   output logic                            pulse_generator_output1_o,
   output logic                            irq_o
);
   import sdtc_pkg::*;

   localparam int NCH = 2;

   // Software registers
   logic                    en_r;
   logic                    auto_r;
   logic [POS_W-1:0]        period_r;
   logic [POS_W-1:0]        rise_r;
   logic [POS_W-1:0]        nomfall_r;
   logic [WIN_W-1:0]        blank_r;
   logic [WIN_W-1:0]        len_r;
   logic [ADJ_W-1:0]        manual_r;
   logic [ADJ_W-1:0]        clmax_r;
   logic [ADJ_W-1:0]        clmin_r;
   logic [CNT_W-1:0]        target_r;
   logic [CNT_W-1:0]        hyst_r;
   logic [CNT_W-1:0]        fthr_r;
   logic [ADJ_W-1:0]        fstep_r;
   logic [FLT_W-1:0]        fnum_r;
   logic [ST_W-1:0]         status_r;
   logic [ST_W-1:0]         mask_r;
   logic [ST_W-1:0]         status_nxt;

   // Per-rectifier state
   logic [NCH-1:0]          sense_m_r;
   logic [NCH-1:0]          sense_s_r;
   logic [NCH-1:0]          gate_fall;
   logic [NCH-1:0]          done;
   logic [NCH-1:0]          flag;
   logic [NCH-1:0]          step_take;
   logic [CNT_W-1:0]        count      [NCH];
   logic signed [ADJ_W-1:0] adj_r      [NCH];
   logic signed [ADJ_W-1:0] adj_nxt    [NCH];
   logic [FLT_W-1:0]        fcnt_r     [NCH];
   logic [FLT_W-1:0]        fcnt_nxt   [NCH];
   logic [POS_W-1:0]        fall_eff_r [NCH];
   logic [POS_W-1:0]        fall_calc  [NCH];

   // Period generator
   logic [POS_W-1:0]        pcnt_r;
   logic [POS_W-1:0]        half;
   logic                    wrap;
   logic [POS_W-1:0]        pos      [NCH];
   logic [NCH-1:0]          in_half;
   logic [NCH-1:0]          half_start;
   logic [NCH-1:0]          pwm_nxt;
   logic [NCH-1:0]          pwm_r;

   // Bus decode
   logic                    req;
   logic                    wr_en;
   logic [31:0]             rd_mux;
   logic                    ack_nxt;
   logic [31:0]             wr_merged;

   // Byte-lane merge for a write, used by the PERIOD, RISE, NOMFALL, MANUAL and CLAMP registers
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return res;
   endfunction

   // Clamp a signed position into a window of positions
   function automatic logic [POS_W-1:0] clamp_pos(input logic signed [POS_W+1:0] v,
                                                  input logic [POS_W-1:0]        hi);
      logic [POS_W-1:0] res;
      res = v[POS_W-1:0];
      if (v < 0) res = '0;
      else if (v > $signed({2'b00, hi})) res = hi;
      return res;
   endfunction

   // Write-one-to-clear status with set winning over clear
   assign req        = wb_cyc_i && wb_stb_i;
   assign wr_en      = req && wb_we_i && wb_ack_o;
   assign ack_nxt    = req && !wb_ack_o;
   assign wr_merged  = merge(rd_mux, wb_dat_i, wb_sel_i);   // Old value under new lanes
   assign status_nxt = (status_r & ~((wr_en && wb_adr_i == REG_STATUS && wb_sel_i[0])
                                     ? wb_dat_i[ST_W-1:0] : {ST_W{1'b0}}))
                       | {step_take, flag};

   // Read selection; unmapped addresses read as zero
   always_comb begin
      rd_mux = '0;
      case (wb_adr_i)
         REG_CTRL: begin
            rd_mux[CTRL_EN_BIT]   = en_r;
            rd_mux[CTRL_AUTO_BIT] = auto_r;
         end
         REG_PERIOD:  rd_mux[POS_W-1:0] = period_r;
         REG_RISE:    rd_mux[POS_W-1:0] = rise_r;
         REG_NOMFALL: rd_mux[POS_W-1:0] = nomfall_r;
         REG_WINDOW:  rd_mux = {16'h0000, len_r, blank_r};
         REG_MANUAL:  rd_mux[ADJ_W-1:0] = manual_r;
         REG_CLAMP:   rd_mux = {clmin_r, clmax_r};
         REG_TARGET:  rd_mux = {17'h00000, hyst_r, 1'b0, target_r};
         REG_FAULT:   rd_mux = {12'h000, fnum_r, fstep_r[7:0], 1'b0, fthr_r};
         REG_COUNTS:  rd_mux = {17'h00000, count[1], 1'b0, count[0]};
         REG_ADJ:     rd_mux = {adj_r[1], adj_r[0]};
         REG_STATUS:  rd_mux[ST_W-1:0] = status_r;
         REG_MASK:    rd_mux[ST_W-1:0] = mask_r;
         default:     rd_mux = '0;
      endcase
   end

   // Bus slave: ack one cycle after the request, write on the acked edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= ack_nxt;
         wb_dat_o <= ack_nxt ? rd_mux : 32'h0000_0000;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_r      <= 1'b0;
         auto_r    <= 1'b0;
         period_r  <= PERIOD_RST;
         rise_r    <= RISE_RST;
         nomfall_r <= NOMFALL_RST;
         blank_r   <= BLANK_RST;
         len_r     <= LEN_RST;
         manual_r  <= '0;
         clmax_r   <= CLMAX_RST;
         clmin_r   <= CLMIN_RST;
         target_r  <= TARGET_RST;
         hyst_r    <= HYST_RST;
         fthr_r    <= FTHR_RST;
         fstep_r   <= FSTEP_RST;
         fnum_r    <= FNUM_RST;
         mask_r    <= '0;
      end else if (wr_en) begin
         case (wb_adr_i)
            REG_CTRL: if (wb_sel_i[0]) begin
               en_r   <= wb_dat_i[CTRL_EN_BIT];                   // [R10]
               auto_r <= wb_dat_i[CTRL_AUTO_BIT];
            end
            REG_PERIOD:  period_r  <= wr_merged[POS_W-1:0];
            REG_RISE:    rise_r    <= wr_merged[POS_W-1:0];
            REG_NOMFALL: nomfall_r <= wr_merged[POS_W-1:0];
            REG_WINDOW: begin
               if (wb_sel_i[0]) blank_r <= wb_dat_i[WIN_W-1:0];
               if (wb_sel_i[1]) len_r   <= wb_dat_i[BYTE1_LSB +: WIN_W];
            end
            REG_MANUAL:  manual_r  <= wr_merged[ADJ_W-1:0];
            REG_CLAMP: begin
               clmax_r <= wr_merged[ADJ_W-1:0];
               clmin_r <= wr_merged[HI_LSB +: ADJ_W];
            end
            REG_TARGET: begin
               if (wb_sel_i[0]) target_r <= wb_dat_i[CNT_W-1:0];
               if (wb_sel_i[1]) hyst_r   <= wb_dat_i[BYTE1_LSB +: CNT_W];
            end
            REG_FAULT: begin
               if (wb_sel_i[0]) fthr_r  <= wb_dat_i[CNT_W-1:0];
               if (wb_sel_i[1]) fstep_r <= {8'h00, wb_dat_i[BYTE1_LSB +: 8]};
               if (wb_sel_i[2]) fnum_r  <= wb_dat_i[FLT_NUM_LSB +: FLT_W];
            end
            REG_MASK: if (wb_sel_i[0]) mask_r <= wb_dat_i[ST_W-1:0];
            default: ;
         endcase
      end
   end

   // Status and level interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= '0;
         irq_o    <= 1'b0;
      end else begin
         status_r <= status_nxt;
         irq_o    <= |(status_nxt & mask_r);
      end
   end

   // Switching period: rect0 owns the first half, rect1 the second
   assign half          = {1'b0, period_r[POS_W-1:1]};
   assign wrap          = (pcnt_r + 16'h0001 >= period_r);
   assign in_half[0]    = (pcnt_r < half);
   assign in_half[1]    = !in_half[0];
   assign pos[0]        = pcnt_r;
   assign pos[1]        = pcnt_r - half;
   assign half_start[0] = wrap;
   assign half_start[1] = (pcnt_r + 16'h0001 == half);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pcnt_r <= '0;
      end else begin
         pcnt_r <= wrap ? 16'h0000 : pcnt_r + 16'h0001;
      end
   end

   // Drain-sense inputs are off-chip: two flops before any use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sense_m_r <= '0;
         sense_s_r <= '0;
      end else begin
         sense_m_r <= ~{conduction_sense1_n_i, conduction_sense0_n_i};
         sense_s_r <= sense_m_r;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_rect
         logic signed [POS_W+1:0] raw_fall;
         logic signed [ADJ_W+1:0] step_sum;
         logic signed [ADJ_W+1:0] cl_sum;
         logic [CNT_W:0]          band_lo;
         logic [CNT_W:0]          band_hi;
         logic                    below;
         logic                    above;
         logic [FLT_W-1:0]        fneed;

         // Pulse: on from rise to the compensated fall inside its own half
         assign pwm_nxt[ch] = in_half[ch] && (pos[ch] >= rise_r)
                              && (pos[ch] < fall_eff_r[ch]);
         assign gate_fall[ch] = pwm_r[ch] && !pwm_nxt[ch];

         sdtc_window u_win (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .gate_fall_i (gate_fall[ch]),
            .sense_low_i (sense_s_r[ch]),
            .blank_i     (blank_r),
            .length_i    (len_r),
            .count_o     (count[ch]),
            .done_o      (done[ch])
         );

         // Fault flag and consecutive filter
         assign fneed        = (fnum_r == '0) ? 4'h1 : fnum_r;
         assign flag[ch]     = done[ch] && (count[ch] < fthr_r);             // [R7]
         assign step_take[ch] = flag[ch] && auto_r && en_r
                                && (fcnt_r[ch] >= fneed - 4'h1);             // [R9]
         assign fcnt_nxt[ch] = !done[ch] ? fcnt_r[ch] :
                               (!flag[ch] || step_take[ch]) ? 4'h0 :
                               (fcnt_r[ch] == 4'hF) ? fcnt_r[ch] : fcnt_r[ch] + 4'h1;

         // Hysteresis band around the target
         assign band_lo = ({1'b0, target_r} > {1'b0, hyst_r}) ?
                          {1'b0, target_r} - {1'b0, hyst_r} : 8'h00;
         assign band_hi = {1'b0, target_r} + {1'b0, hyst_r};
         assign below   = ({1'b0, count[ch]} < band_lo);                    // [R6]
         assign above   = ({1'b0, count[ch]} > band_hi);                    // [R6]

         // Step selection: fault first, then target stepping
         always_comb begin
            step_sum = {{2{adj_r[ch][ADJ_W-1]}}, adj_r[ch]};
            if (step_take[ch]) begin
               step_sum = step_sum - $signed({2'b00, fstep_r});              // [R8] [R15]
            end else if (below) begin
               step_sum = step_sum - {{2{1'b0}}, AUTO_STEP};                // [R5] [R14]
            end else if (above) begin
               step_sum = step_sum + {{2{1'b0}}, AUTO_STEP};                // [R5] [R14]
            end
            cl_sum = step_sum;
            if (cl_sum > $signed({{2{clmax_r[ADJ_W-1]}}, clmax_r})) begin
               cl_sum = {{2{clmax_r[ADJ_W-1]}}, clmax_r};                    // [R3] [R15]
            end else if (cl_sum < $signed({{2{clmin_r[ADJ_W-1]}}, clmin_r})) begin
               cl_sum = {{2{clmin_r[ADJ_W-1]}}, clmin_r};                    // [R3]
            end
            if (!en_r) begin
               adj_nxt[ch] = '0;                                             // [R10]
            end else if (!auto_r) begin
               adj_nxt[ch] = manual_r;                                       // [R2]
            end else if (done[ch]) begin
               adj_nxt[ch] = cl_sum[ADJ_W-1:0];
            end else begin
               adj_nxt[ch] = adj_r[ch];
            end
         end

         // Next-cycle edge: nominal plus adjustment, held inside its half
         assign raw_fall      = $signed({2'b00, nomfall_r})
                                + {{2{adj_r[ch][ADJ_W-1]}}, adj_r[ch]};
         assign fall_calc[ch] = clamp_pos(raw_fall, half);                  // [R4]

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               adj_r[ch]      <= '0;
               fcnt_r[ch]     <= '0;
               fall_eff_r[ch] <= '0;
               pwm_r[ch]      <= 1'b0;
            end else begin
               adj_r[ch]  <= adj_nxt[ch];
               fcnt_r[ch] <= fcnt_nxt[ch];
               pwm_r[ch]  <= pwm_nxt[ch];
               if (half_start[ch]) begin
                  fall_eff_r[ch] <= fall_calc[ch];                           // [R13]
               end
            end
         end
      end
   endgenerate

   // Pulse outputs straight from their flops
   assign pulse_generator_output0_o = pwm_r[0];
   assign pulse_generator_output1_o = pwm_r[1];
endmodule

// *** hw/sdtc_pkg.sv ***
// Purpose: Shared constants and types of the rectifier dead-time compensator.
// Assumes: 32-bit classic Wishbone register bus, byte addresses, 200 MHz clock.
// Notes:   Counts and times are in clock cycles of the single block clock.
package sdtc_pkg;
   // Widths
   localparam int CNT_W  = 7;                // Conduction count, 0 to 127
   localparam int POS_W  = 16;               // Period and edge positions
   localparam int ADJ_W  = 16;               // Signed edge adjustment
   localparam int WIN_W  = 8;                // Blanking and window lengths
   localparam int FLT_W  = 4;                // Consecutive fault counter
   localparam int ADR_W  = 8;                // Byte address bits decoded

   // Register byte offsets
   localparam logic [ADR_W-1:0] REG_CTRL    = 8'h00;
   localparam logic [ADR_W-1:0] REG_PERIOD  = 8'h04;
   localparam logic [ADR_W-1:0] REG_RISE    = 8'h08;
   localparam logic [ADR_W-1:0] REG_NOMFALL = 8'h0C;
   localparam logic [ADR_W-1:0] REG_WINDOW  = 8'h10;
   localparam logic [ADR_W-1:0] REG_MANUAL  = 8'h14;
   localparam logic [ADR_W-1:0] REG_CLAMP   = 8'h18;
   localparam logic [ADR_W-1:0] REG_TARGET  = 8'h1C;
   localparam logic [ADR_W-1:0] REG_FAULT   = 8'h20;
   localparam logic [ADR_W-1:0] REG_COUNTS  = 8'h24;
   localparam logic [ADR_W-1:0] REG_ADJ     = 8'h28;
   localparam logic [ADR_W-1:0] REG_STATUS  = 8'h2C;
   localparam logic [ADR_W-1:0] REG_MASK    = 8'h30;

   // Field positions
   localparam int CTRL_EN_BIT   = 0;         // compensation_enable
   localparam int CTRL_AUTO_BIT = 1;         // 1 automatic, 0 manual
   localparam int HI_LSB        = 16;        // Upper half-word fields
   localparam int BYTE1_LSB     = 8;         // Second byte fields
   localparam int FLT_NUM_LSB   = 16;        // Consecutive fault number
   localparam int ST_FLAG_LSB   = 0;         // Fault flagged, one per rectifier
   localparam int ST_STEP_LSB   = 2;         // Fault step taken, one per rectifier
   localparam int ST_W          = 4;

   // Reset values
   localparam logic [POS_W-1:0] PERIOD_RST  = 16'h00C8;
   localparam logic [POS_W-1:0] RISE_RST    = 16'h0004;
   localparam logic [POS_W-1:0] NOMFALL_RST = 16'h0050;
   localparam logic [WIN_W-1:0] BLANK_RST   = 8'h02;
   localparam logic [WIN_W-1:0] LEN_RST     = 8'h18;
   localparam logic [ADJ_W-1:0] CLMAX_RST   = 16'h0020;
   localparam logic [ADJ_W-1:0] CLMIN_RST   = 16'hFFE0;
   localparam logic [CNT_W-1:0] TARGET_RST  = 7'h08;
   localparam logic [CNT_W-1:0] HYST_RST    = 7'h02;
   localparam logic [CNT_W-1:0] FTHR_RST    = 7'h01;
   localparam logic [ADJ_W-1:0] FSTEP_RST   = 16'h0008;
   localparam logic [FLT_W-1:0] FNUM_RST    = 4'h3;

   // Automatic-mode step and count saturation
   localparam logic signed [ADJ_W-1:0] AUTO_STEP = 16'sh0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;

   // Detection window sequencer
   typedef enum logic [1:0] {
      SDTC_IDLE,
      SDTC_BLANK,
      SDTC_OPEN
   } sdtc_win_state_type;
endpackage

// *** hw/sdtc_window.sv ***
// Purpose: Detection window and conduction timer for one rectifier.
// Assumes: sense_low_i is already synchronised; gate_fall_i is one-cycle pulse.
// Notes:   A new falling edge while the window runs restarts the measurement.
`timescale 1ns/10ps
module sdtc_window (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       gate_fall_i,
   input  wire logic                       sense_low_i,
   input  wire logic [sdtc_pkg::WIN_W-1:0] blank_i,
   input  wire logic [sdtc_pkg::WIN_W-1:0] length_i,
   output logic      [sdtc_pkg::CNT_W-1:0] count_o,
   output logic                            done_o
);
   import sdtc_pkg::*;

   sdtc_win_state_type       state_r;
   sdtc_win_state_type       state_nxt;
   logic [WIN_W-1:0]         tmr_r;
   logic [CNT_W-1:0]         acc_r;
   logic                     blank_end;
   logic                     open_end;

   // Window opens after blanking and closes after its length; zero blanking still takes one cycle
   assign blank_end = (tmr_r >= blank_i);
   assign open_end  = (tmr_r + 8'h01 >= length_i);

   // Window sequence, restarted on every gate-command falling edge
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SDTC_IDLE:  if (gate_fall_i) state_nxt = SDTC_BLANK;    // [R1]
         SDTC_BLANK: if (blank_end)   state_nxt = SDTC_OPEN;     // [R1]
         SDTC_OPEN:  if (open_end)    state_nxt = SDTC_IDLE;     // [R1]
         default:    state_nxt = SDTC_IDLE;
      endcase
      if (gate_fall_i) state_nxt = SDTC_BLANK;
   end

   // Timer and conduction accumulation, saturating at the top count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= SDTC_IDLE;
         tmr_r   <= '0;
         acc_r   <= '0;
         count_o <= '0;
         done_o  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         done_o  <= 1'b0;
         if (gate_fall_i || (state_r != state_nxt)) begin
            tmr_r <= '0;
         end else begin
            tmr_r <= tmr_r + 8'h01;
         end
         if (gate_fall_i) begin
            acc_r <= '0;
         end else if (state_r == SDTC_OPEN && sense_low_i && acc_r != CNT_MAX) begin
            acc_r <= acc_r + 7'h01;                               // [R11] [R12]
         end
         if (state_r == SDTC_OPEN && open_end && !gate_fall_i) begin
            count_o <= (sense_low_i && acc_r != CNT_MAX) ? acc_r + 7'h01 : acc_r;
            done_o  <= 1'b1;
         end
      end
   end
endmodule

// *** tb/sdtc_core_chk.sv ***
// Purpose: Port checks on bus answers and gate timing.
// Assumes: Period keeps its reset value of 200 cycles.
// Notes:   Bound to the core below; sees its ports only.
`timescale 1ns/10ps
module sdtc_core_chk (
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [sdtc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]                 wb_sel_i,
   input wire logic [31:0]                wb_dat_i,
   input wire logic [31:0]                wb_dat_o,
   input wire logic                       wb_ack_o,
   input wire logic                       conduction_sense0_n_i,
   input wire logic                       conduction_sense1_n_i,
   input wire logic                       pulse_generator_output0_o,
   input wire logic                       pulse_generator_output1_o,
   input wire logic                       irq_o
);
   logic [7:0] on_r;
   // Rect0 on-time so far; the natural clamp keeps it under half a period
   always_ff @(posedge clk_i) begin
      on_r <= (rst_i || !pulse_generator_output0_o) ? 8'h00 : on_r + 8'h01;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data out of ack");
   gate_excl_a: assert property (!(pulse_generator_output0_o && pulse_generator_output1_o))
      else $error("gates overlap");
   gate_width_a: assert property (on_r < 8'h64) else $error("gate past half period");
   half_offset_a: assert property ($rose(pulse_generator_output0_o) |->
      ##100 $rose(pulse_generator_output1_o)) else $error("rect1 not at half period");
   gate_period_a: assert property ($rose(pulse_generator_output0_o) |->
      ##200 $rose(pulse_generator_output0_o)) else $error("period wrong");
   cover property (wb_ack_o && wb_we_i);
   cover property ($rose(irq_o));
   cover property ($fell(pulse_generator_output1_o));
endmodule
bind sdtc_core sdtc_core_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .conduction_sense0_n_i(conduction_sense0_n_i),
   .conduction_sense1_n_i(conduction_sense1_n_i),
   .pulse_generator_output0_o(pulse_generator_output0_o),
   .pulse_generator_output1_o(pulse_generator_output1_o));

// *** tb/sdtc_core_test.sv ***
// Purpose: Self-checking bench for the dead-time compensator.
// Assumes: Driver models place sense pulses well inside each window.
// Notes:   Expected adjustments come from an integer model of the loop.
`timescale 1ns/10ps
module sdtc_core_test;
   import sdtc_pkg::*;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, p0, p1, irq, s0, s1;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, rdat, q, e;
   logic [6:0]  len0 = 7'h00, len1 = 7'h00;
   logic [15:0] seed = 16'h8842;
   int          err_total, n_checks, adj, fc, thr = 1, l;
   logic [7:0]  ra [7] = '{REG_CTRL, REG_PERIOD, REG_WINDOW, REG_CLAMP, REG_TARGET, REG_FAULT, 8'h40};
   logic [31:0] rv [7] = '{32'h0, 32'hC8, 32'h1802, 32'hFFE00020, 32'h208, 32'h30801, 32'h0};
   always #2.5 clk = ~clk;
   sdtc_core uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .conduction_sense0_n_i(s0), .conduction_sense1_n_i(s1), .irq_o(irq),
      .pulse_generator_output0_o(p0), .pulse_generator_output1_o(p1));
   sdtc_drv_model drv0 (.clk_i(clk), .gate_i(p0), .len_i(len0), .sense_n_o(s0));
   sdtc_drv_model drv1 (.clk_i(clk), .gate_i(p1), .len_i(len1), .sense_n_o(s1));
   // Mismatches are reported at once and counted
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) err_total++;
      if (seen !== exp) $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
   endtask
   // Classic cycle: request held until ack is sampled, then one idle cycle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   // Wait past the window that follows k rect0 turn-offs
   task automatic falls(input int k);
      repeat (k) @(negedge p0);
      repeat (40) @(posedge clk);
   endtask
   // Loop model: a due fault step wins, else one step toward the band, then clamps
   function automatic void upd(input int c);
      fc = (c < thr) ? fc + 1 : 0;
      if (fc >= 3) adj -= 8;
      else if (c < 6) adj--;
      else if (c > 10) adj++;
      if (fc >= 3) fc = 0;
      adj = (adj > 32) ? 32 : (adj < -32) ? -32 : adj;
   endfunction
   function automatic logic [15:0] xs(input logic [15:0] v);
      v ^= v << 7;
      v ^= v >> 9;
      return v ^ (v << 8);
   endfunction
   task automatic results;
      $display("checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // About 25000 cycles are needed; a hang is cut at four times that
   initial begin
      #500000;
      err_total++;
      results();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (ra[i]) rd(ra[i], rv[i]);
      $display("reset values done");
      // Manual mode with random conduction times on both rectifiers
      seed = xs(seed);
      e = {17'h0, 7'(seed % 16'd17), 1'b0, 7'(seed % 16'd19)};
      {len1, len0} <= {e[14:8], e[6:0]};
      xfer(1'b1, REG_MANUAL, 32'h5);
      xfer(1'b1, REG_CTRL, 32'h1);
      falls(2);
      rd(REG_COUNTS, e);
      xfer(1'b1, REG_COUNTS, 32'h0);
      rd(REG_COUNTS, e);
      rd(REG_ADJ, 32'h00050005);
      xfer(1'b1, REG_CTRL, 32'h0);
      falls(1);
      rd(REG_ADJ, 32'h0);
      $display("manual mode done");
      // Automatic mode: ramp, band, ramp down, ramp up, then repeated faults
      @(negedge p1); // Enable well away from the close of a rect0 window
      xfer(1'b1, REG_CTRL, 32'h3);
      for (int i = 0; i < 120; i++) begin
         seed = xs(seed);
         l = (i < 40) ? 15 : (i < 50) ? 6 + seed % 5 : (i < 90) ? 2 : (i < 100) ? 11 + seed % 8 : 2;
         thr = (i >= 100) ? 5 : 1;
         if (i == 100) xfer(1'b1, REG_FAULT, 32'h00030805);
         {len1, len0} <= {7'(l), 7'(l)};
         falls(1);
         upd(l);
         xfer(1'b0, REG_ADJ, 32'h0);
         chk(q & 32'hFFFF, 32'(adj) & 32'hFFFF);
      end
      $display("automatic mode done");
      // Sticky status, mask and write-one-to-clear
      {len1, len0} <= {7'hF, 7'hF};
      falls(2);
      rd(REG_STATUS, 32'hF);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, REG_MASK, 32'h4);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, REG_STATUS, 32'h4);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(REG_STATUS, 32'hB);
      $display("status done");
      results();
   end
endmodule

// *** tb/sdtc_drv_model.sv ***
// Purpose: Rectifier driver model, one low sense pulse after each gate turn-off.
// Assumes: The bench changes len_i only between turn-offs.
// Notes:   Idles high, the comparator level for no diode conduction.
`timescale 1ns/10ps
module sdtc_drv_model (
   input  wire logic       clk_i,
   input  wire logic       gate_i,
   input  wire logic [6:0] len_i,
   output logic            sense_n_o
);
   logic gate_q = 1'b0;
   int   t_q    = 100;
   logic sn_r   = 1'b1;
   // Low from 5 cycles after the fall, so the pulse sits inside the window
   always @(posedge clk_i) begin
      gate_q <= gate_i;
      t_q    <= (gate_q && !gate_i) ? 0 : t_q + 1;
      sn_r   <= !(t_q >= 3 && t_q < 3 + int'(len_i));
   end
   assign sense_n_o = sn_r;
endmodule
